// *** hdl/ipr_core.sv ***
// module: internal-parameter conversion sequencer with a spare filter for redundancy checking
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - one command converts stack sum, die temperature, analog and digital supply.
// - any of the eight filter modes may be chosen by the command.
// - total time for all four follows the per-mode table, e.g. 742 us.
// - stack sum code is a 16-bit conversion of top-to-bottom voltage over thirty.
// - stack sum code weighs 30 times 100 uV per bit.
// - die temperature code is 16 bits; degrees = code*100uV/7.6mV - 276.
// - analog supply in group A, digital supply in group B, 100 uV per bit.
// - redundant command takes exactly as long as the plain one.
// - each of three converters has a filter machine; a fourth serves redundancy.
// - the plain internal-parameter command never applies redundancy.
// - during redundancy the bitstream feeds primary and spare machines together.
// - results compared bit by bit at end; mismatch stores the fault code.
// - fault code upper twelve bits are 0xff0, outside 0x0000..0xdfff.
// - fault code low bits flag mismatching nibbles, bit 3 for bits 15-12.
// - a fault code never has its low four bits all zero.
// - only one converter is covered; path chosen automatically or by select.
// - while force-fail is set, every comparison reports a mismatch.
// - select 01 uses converter 1 checked; 10 and 11 use converters 2, 3 unchecked.
module ipr_core
    import ipr_pkg::*;
#(
    parameter int unsigned CYCLES_PER_US = CLK_MHZ
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // modulator bitstreams of the three converters
    input wire logic [2:0] mod_bit,
    // interrupt
    output logic irq
);
    // ****************************************************************
    // registers
    // ****************************************************************
    ipr_state_t state_reg, state_next;
    logic [2:0] mode_reg;
    logic red_active_reg;
    logic [1:0] conv_adc_reg;
    logic [1:0] path_select_reg;
    logic force_fail_reg;
    logic [1:0] param_idx_reg;
    logic [31:0] slot_cnt_reg;
    logic [15:0] result_reg [PARAM_COUNT];
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [31:0] rdata_reg;
    logic [15:0] acc_reg [4];

    // ****************************************************************
    // register decode
    // ****************************************************************
    wire logic wr_cmd = reg_wr && (reg_addr == OFS_CMD);
    wire logic wr_cfg = reg_wr && (reg_addr == OFS_CFG);
    wire logic wr_irq_stat = reg_wr && (reg_addr == OFS_IRQ_STAT);
    wire logic wr_irq_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);
    wire logic idle = (state_reg == IPR_IDLE);
    // a command while busy is dropped so a running sequence keeps its timing
    wire logic start_plain = wr_cmd && idle && reg_wdata[CMD_PLAIN_BIT];
    wire logic start_red = wr_cmd && idle && !reg_wdata[CMD_PLAIN_BIT]
                           && reg_wdata[CMD_RED_BIT];
    wire logic start = start_plain || start_red;
    wire logic [2:0] start_mode = reg_wdata[CMD_MODE_LSB +: 3];
    wire logic [1:0] path_now = path_select_reg;

    // path choice: auto and 01 use converter 1, 10 and 11 use converters 2 and 3
    wire logic path_checks = (path_now == PATH_AUTO) || (path_now == PATH_ADC1);
    wire logic [1:0] start_adc = path_checks ? 2'h0 :
                                 (path_now == PATH_ADC2) ? 2'h1 : 2'h2;
    // plain command never checks; redundant only on a checked path
    wire logic start_red_on = start_red && path_checks;

    // ****************************************************************
    // timing
    // ****************************************************************
    // four equal slots: the redundant command shares the plain timing
    wire logic [31:0] total_cycles = T4C_US[mode_reg] * CYCLES_PER_US;
    wire logic [31:0] slot_cycles_raw = total_cycles / PARAM_COUNT;
    wire logic [31:0] slot_cycles = (slot_cycles_raw == 32'h0) ? 32'h1 : slot_cycles_raw;
    wire logic slot_end = (state_reg == IPR_CONV) && (slot_cnt_reg == slot_cycles - 32'h1);
    wire logic last_param = (param_idx_reg == 2'(PARAM_COUNT - 1));

    // ****************************************************************
    // filter machines
    // ****************************************************************
    // the spare machine listens to the covered converter only when checking
    wire logic spare_bit = red_active_reg && mod_bit[conv_adc_reg];
    wire logic [3:0] machine_in = {spare_bit, mod_bit};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_machine
            // ones counter stands in for the integrate and dump, clipped to the valid span
            always_ff @(posedge clock) begin
                if (sys_rst || start || slot_end) begin
                    acc_reg[gi] <= RESULT_RST;
                end else if (state_reg == IPR_CONV && machine_in[gi]
                             && acc_reg[gi] != RESULT_MAX) begin
                    acc_reg[gi] <= acc_reg[gi] + 16'h0001;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // comparison and fault code
    // ****************************************************************
    wire logic [15:0] primary = acc_reg[conv_adc_reg];
    // forcing flips the spare's lowest bit, so the low nibble flag is always set
    wire logic [15:0] spare = acc_reg[3] ^ {15'h0, force_fail_reg};
    wire logic [15:0] diff = primary ^ spare;
    wire logic [3:0] nib_flag = {|diff[15:12], |diff[11:8], |diff[7:4], |diff[3:0]};
    // a fault is only declared with a flag set, so all-zero flags never appear
    wire logic mismatch = red_active_reg && (nib_flag != 4'h0);
    wire logic [15:0] fault_code = {FAULT_UPPER, nib_flag};
    wire logic [15:0] slot_result = mismatch ? fault_code : primary;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IPR_IDLE: begin
                if (start) begin
                    state_next = IPR_CONV;
                end
            end
            IPR_CONV: begin
                if (slot_end) begin
                    state_next = last_param ? IPR_STORE : IPR_CONV;
                end
            end
            IPR_STORE: begin
                state_next = IPR_IDLE;
            end
            default: begin
                state_next = IPR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= IPR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_reg <= 3'h0;
            red_active_reg <= 1'b0;
            conv_adc_reg <= 2'h0;
        end else if (start) begin
            mode_reg <= start_mode;
            red_active_reg <= start_red_on;
            conv_adc_reg <= start_adc;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || start || slot_end) begin
            slot_cnt_reg <= 32'h0;
        end else if (state_reg == IPR_CONV) begin
            slot_cnt_reg <= slot_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || start) begin
            param_idx_reg <= 2'h0;
        end else if (slot_end) begin
            param_idx_reg <= param_idx_reg + 2'h1;
        end
    end

    // slot order: stack sum, die temperature, analog supply, digital supply
    // codes are stored raw; scaling (30x100uV, 100uV/7.6mV-276, 100uV) is software's
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < PARAM_COUNT; i++) begin
                result_reg[i] <= RESULT_RST;
            end
        end else if (slot_end) begin
            result_reg[param_idx_reg] <= slot_result;
        end
    end

    // ****************************************************************
    // configuration
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            path_select_reg <= PATH_AUTO;
            force_fail_reg <= 1'b0;
        end else if (wr_cfg) begin
            path_select_reg <= reg_wdata[CFG_PATH_LSB +: 2];
            force_fail_reg <= reg_wdata[CFG_FORCE_BIT];
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    wire logic ev_done = (state_reg == IPR_STORE);
    wire logic ev_fault = slot_end && mismatch;
    wire logic [1:0] ev_set = {ev_fault, ev_done};

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_stat_reg <= 2'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_irq_stat ? reg_wdata[1:0] : 2'h0)) | ev_set;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_mask_reg <= 2'h0;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= reg_wdata[1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ****************************************************************
    // read back
    // ****************************************************************
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            OFS_CMD: rd_mux = {25'h0, mode_reg, 4'h0};
            OFS_CFG: rd_mux = {29'h0, force_fail_reg, path_select_reg};
            OFS_STAT: rd_mux = {26'h0, conv_adc_reg, param_idx_reg, red_active_reg, !idle};
            OFS_SUM: rd_mux = {16'h0, result_reg[0]};
            OFS_TEMP: rd_mux = {16'h0, result_reg[1]};
            OFS_VANA: rd_mux = {16'h0, result_reg[2]};
            OFS_VDIG: rd_mux = {16'h0, result_reg[3]};
            OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_reg};
            OFS_IRQ_MASK: rd_mux = {30'h0, irq_mask_reg};
            default: rd_mux = 32'h0;
        endcase
    end

    // data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clock) begin
        if (sys_rst || !reg_rd) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rd_mux;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule

// *** hdl/ipr_pkg.sv ***
// package: constants for the internal-parameter conversion block with redundancy check
package ipr_pkg;
    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned PARAM_COUNT = 4;
    // total time in us for all four parameters, per filter mode 0..7
    // modes: 27kHz, 14kHz, 7kHz, 3kHz, 2kHz, 1kHz, 422Hz, 26Hz
    localparam int unsigned T4C_US [8] = '{742, 858, 1556, 2022, 2953, 4814, 8538, 134211};

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_SUM = 8'h0c;
    localparam logic [7:0] OFS_TEMP = 8'h10;
    localparam logic [7:0] OFS_VANA = 8'h14;
    localparam logic [7:0] OFS_VDIG = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int CMD_PLAIN_BIT = 0;
    localparam int CMD_RED_BIT = 1;
    localparam int CMD_MODE_LSB = 4;
    localparam int CFG_PATH_LSB = 0;
    localparam int CFG_FORCE_BIT = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;

    // ****************************************************************
    // values
    // ****************************************************************
    localparam logic [11:0] FAULT_UPPER = 12'hff0;
    localparam logic [15:0] RESULT_MAX = 16'hdfff;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [1:0] PATH_AUTO = 2'h0;
    localparam logic [1:0] PATH_ADC1 = 2'h1;
    localparam logic [1:0] PATH_ADC2 = 2'h2;

    typedef enum logic [1:0] {
        IPR_IDLE = 2'b00,
        IPR_CONV = 2'b01,
        IPR_STORE = 2'b10
    } ipr_state_t;
endpackage

// *** verif/ipr_mod_src.sv ***
// partner: modulator bitstream source for the three converters
`timescale 1ns/1ps
module ipr_mod_src (
    // clock
    input wire logic clock,
    // steady level per converter
    input wire logic [2:0] level,
    // bitstreams to the block
    output logic [2:0] mod_bit = 3'h0
);
    // a steady stream keeps a slot's ones count exact whatever the slot alignment
    always @(posedge clock) begin
        mod_bit <= level;
    end
endmodule

// *** verif/ipr_monitor.sv ***
// checker: port-level assertions for the internal-parameter conversion block
`timescale 1ns/1ps
module ipr_monitor
    import ipr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // converter side and interrupt
    input wire logic [2:0] mod_bit,
    input wire logic irq
);
    wire logic is_res;
    assign is_res = reg_addr >= OFS_SUM && reg_addr <= OFS_VDIG && reg_addr[1:0] == 2'h0;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ****************************************************************
    // assertions
    // ****************************************************************
    chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside its cycle");
    chk_reset_clear: assert property ($past(sys_rst) |-> !irq && reg_rdata == 32'h0)
        else $error("outputs not cleared by reset");
    chk_result_span: assert property (reg_rd && is_res |=> reg_rdata[31:16] == 16'h0 &&
        (reg_rdata[15:0] <= RESULT_MAX || reg_rdata[15:4] == FAULT_UPPER))
        else $error("result outside valid span and not a fault code");
    chk_fault_flags: assert property (reg_rd && is_res ##1 reg_rdata[15:4] == FAULT_UPPER
        |-> reg_rdata[3:0] != 4'h0)
        else $error("fault code without nibble flags");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > OFS_IRQ_MASK |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_cfg_readback: assert property (reg_wr && reg_addr == OFS_CFG ##1
        reg_rd && reg_addr == OFS_CFG |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2))
        else $error("config read back differs from write");
    chk_stat_upper: assert property (reg_rd && reg_addr == OFS_STAT |=> reg_rdata[31:6] == 26'h0)
        else $error("status upper bits not zero");
    chk_irq_drop: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("interrupt dropped without a register write");
endmodule
bind ipr_core ipr_monitor u_ipr_monitor (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mod_bit(mod_bit), .irq(irq));

// *** verif/tb_top.sv ***
// testbench: conversion runs, redundancy, forced faults and path selection
`timescale 1ns/1ps
module tb_top
    import ipr_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [2:0] mod_bit;
    logic [2:0] level = 3'h0;
    logic irq;
    logic [31:0] d;
    int n_fail = 0;
    int checks_done = 0;
    int seed = 63984;
    int n_plain;
    int n_red;
    ipr_core #(.CYCLES_PER_US(1)) u_ipr_core (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mod_bit(mod_bit), .irq(irq));
    ipr_mod_src u_ipr_mod_src (.clock(clock), .level(level), .mod_bit(mod_bit));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // tasks are entered just after a rising edge and return at one
    // a write leaves its strobe up, so back-to-back writes never drop and raise it at one edge;
    // the next read or wait lowers it
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_wr <= 1'b0;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock) reg_rd <= 1'b0;
        @(posedge clock) v = reg_rdata;
    endtask
    function automatic logic [15:0] slot_val(input int m, input logic lvl);
        // the slot's closing cycle restarts the count, so a slot yields one bit less than its length
        return lvl ? 16'(T4C_US[m] / 4 - 1) : 16'h0;
    endfunction
    task automatic run(input int m, input logic red, output int n);
        wr(OFS_CMD, (32'(m) << CMD_MODE_LSB) | (red ? 32'h2 : 32'h1));
        reg_wr <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 40000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 40000) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic results(input logic [15:0] e);
        for (int k = 0; k < 4; k++) begin
            rd(OFS_SUM + 8'(4 * k), d);
            check(d, {16'h0, e});
        end
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        forever #5 clock = ~clock;
    end
    initial begin
        #600000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        d = $random(seed);
        wr(8'h80 | d[7:0], 32'hffff_ffff);
        rd(8'h80 | d[7:0], d);
        check(d, 32'h0);
        results(RESULT_RST);
        wr(OFS_IRQ_MASK, 32'h1);
        // the slowest mode alone would outrun the cycle budget, so it is left out
        for (int m = 0; m < 7; m++) begin
            level <= 3'($random(seed));
            wr(OFS_CFG, 32'(m & 1));
            run(m, 1'b0, n_plain);
            wr(OFS_IRQ_STAT, 32'h3);
            results(slot_val(m, level[0]));
            run(m, 1'b1, n_red);
            wr(OFS_IRQ_STAT, 32'h3);
            results(slot_val(m, level[0]));
            check(n_red, n_plain);
            check(32'(n_plain - 4 * (T4C_US[m] / 4) inside {[1:4]}), 32'h1);
        end
        level <= 3'b101;
        wr(OFS_CFG, 32'h5);
        rd(OFS_CFG, d);
        check(d, 32'h5);
        run(0, 1'b1, n_red);
        results({FAULT_UPPER, 4'h1});
        rd(OFS_IRQ_STAT, d);
        check(d, 32'h3);
        wr(OFS_IRQ_MASK, 32'h0);
        rd(OFS_IRQ_MASK, d);
        check(d, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_STAT, 32'h3);
        wr(OFS_IRQ_MASK, 32'h1);
        run(0, 1'b0, n_plain);
        wr(OFS_IRQ_STAT, 32'h3);
        results(slot_val(0, 1'b1));
        for (int p = 2; p < 4; p++) begin
            wr(OFS_CFG, 32'h4 | 32'(p));
            run(0, 1'b1, n_red);
            wr(OFS_IRQ_STAT, 32'h3);
            results(slot_val(0, level[p - 1]));
        end
        // slowest mode with both start bits: plain wins; only its start is watched, then
        // a reset in mid-run cuts it short and must clear results and configuration
        wr(OFS_CMD, 32'h73);
        rd(OFS_CMD, d);
        check(d, 32'h70);
        rd(OFS_STAT, d);
        check(d, 32'h21);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        results(RESULT_RST);
        rd(OFS_STAT, d);
        check(d, 32'h0);
        rd(OFS_CFG, d);
        check(d, 32'h0);
        tally_and_finish();
    end
endmodule
